// ---- core_model.sv ----
// Behavioural execution core, watchdog and reset logic on the flag bank's core side
`timescale 1ns/1ns

module core_model
(
  input  wire logic                       i_clk,
  output status_flags_pkg::alu_req_type   o_alu_req,
  output status_flags_pkg::sys_event_type o_sys_event
);
  initial
  begin
    o_alu_req = '0;
    o_sys_event = '0;
  end

  // One-cycle ALU request, released at the edge that takes it
  task automatic alu(input status_flags_pkg::alu_op_type op, input logic [7:0] a,
                     input logic [7:0] b);
    @(posedge i_clk);
    o_alu_req <= {1'b1, op, a, b};
    @(posedge i_clk);
    o_alu_req.valid <= 1'b0;
  endtask

  // One-cycle event pulse
  task automatic pulse(input status_flags_pkg::sys_event_type ev);
    @(posedge i_clk);
    o_sys_event <= ev;
    @(posedge i_clk);
    o_sys_event <= '0;
  endtask
endmodule

// ---- status_and_reset_flag_regs.sv ----
// Status and reset-cause flag registers with AXI4-Lite access and ALU flag logic
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "status_flags_defs.svh"

// Functional notes
// - Software write to core flags never changes watchdog expiry or power-down flags.
// - Watchdog expiry flag: cleared at power-up, clear-watchdog, halt; set on timeout.
// - Power-down flag: cleared at power-up and clear-watchdog; set by halt.
// - Carry set on add carry-out or subtract without borrow, else cleared.
// - Rotate through carry shifts old carry in and loads carry with bit out.
// - Half carry set on low-nibble carry, or no nibble borrow on subtract.
// - Zero flag follows whether an arithmetic or logical result is zero.
// - Overflow set when carry into bit 7 differs from carry out.
// - Core flags are never saved automatically on interrupt or call.
// - Top two core flag bits are unimplemented and read zero.
// - Low four arithmetic flag bits are readable and writable by software.
// - Control bit 2 reads one after a low-voltage reset.
// - Control bit 1 reads one after reset caused by low-voltage control write.
// - Reset-cause flags clear on software write of zero, ignore write of one.

module status_and_reset_flag_regs
(
  input  wire logic                      i_clk,
  input  wire logic                      i_resetn,
  // AXI4-Lite slave
  input  wire logic                      i_axi_awvalid,
  output logic                           o_axi_awready,
  input  wire logic [`AXI_ADDR_W-1:0]    i_axi_awaddr,
  input  wire logic                      i_axi_wvalid,
  output logic                           o_axi_wready,
  input  wire logic [31:0]               i_axi_wdata,
  input  wire logic [3:0]                i_axi_wstrb,
  output logic                           o_axi_bvalid,
  input  wire logic                      i_axi_bready,
  output logic [1:0]                     o_axi_bresp,
  input  wire logic                      i_axi_arvalid,
  output logic                           o_axi_arready,
  input  wire logic [`AXI_ADDR_W-1:0]    i_axi_araddr,
  output logic                           o_axi_rvalid,
  input  wire logic                      i_axi_rready,
  output logic [31:0]                    o_axi_rdata,
  output logic [1:0]                     o_axi_rresp,
  // Execution core side
  input  wire status_flags_pkg::alu_req_type   i_alu_req,
  input  wire status_flags_pkg::sys_event_type i_sys_event,
  output logic [7:0]                     o_alu_result,
  output logic                           o_alu_done,
  output logic [7:0]                     o_core_flags,
  output logic [7:0]                     o_system_control_flags,
  output logic                           o_idle_clock_keep
);

  status_flags_pkg::state_type state_reg;
  status_flags_pkg::state_type state_next;

  // ==========================================================
  // Helpers
  // ==========================================================

  // Byte view of the core flags; top bits read zero
  function automatic logic [7:0] core_byte(input status_flags_pkg::state_type s);
    logic [7:0] v;
    v = 8'h00;
    v[`CF_CARRY_BIT] = s.carry_flag;
    v[`CF_HALF_BIT]  = s.half_carry_flag;
    v[`CF_ZERO_BIT]  = s.zero_flag;
    v[`CF_OVF_BIT]   = s.signed_overflow_flag;
    v[`CF_PDOWN_BIT] = s.power_down_flag;
    v[`CF_WDEXP_BIT] = s.watchdog_expiry_flag;
    return v;
  endfunction

  // Byte view of the system control flags; bits 6..3 read zero
  function automatic logic [7:0] ctrl_byte(input status_flags_pkg::state_type s);
    logic [7:0] v;
    v = 8'h00;
    v[`SC_WDEN_BIT]    = s.wd_enable_reset_cause;
    v[`SC_LVCTRL_BIT]  = s.lv_ctrl_write_reset_cause;
    v[`SC_LVR_BIT]     = s.low_voltage_reset_cause;
    v[`SC_IDLECLK_BIT] = s.idle_clock_keep;
    return v;
  endfunction

  // ==========================================================
  // ALU datapath
  // ==========================================================

  logic [7:0] b_eff;
  logic       cin;
  logic [8:0] sum9;
  logic [4:0] sum_lo;
  logic [7:0] sum_low7;
  logic       carry_in7;
  logic       is_arith;
  logic       is_logic;
  logic       is_rot;
  logic [7:0] alu_val;
  logic       rot_carry;

  always_comb
  begin
    is_arith = (i_alu_req.op == status_flags_pkg::OP_ADD) ||
               (i_alu_req.op == status_flags_pkg::OP_SUB);
    is_rot   = (i_alu_req.op == status_flags_pkg::OP_RLC) ||
               (i_alu_req.op == status_flags_pkg::OP_RRC);
    is_logic = (i_alu_req.op == status_flags_pkg::OP_AND) ||
               (i_alu_req.op == status_flags_pkg::OP_OR) ||
               (i_alu_req.op == status_flags_pkg::OP_XOR);
    // Subtract as a + ~b + 1, so carry out means no borrow
    if (i_alu_req.op == status_flags_pkg::OP_SUB)
    begin
      b_eff = ~i_alu_req.b;
      cin   = 1'b1;
    end
    else
    begin
      b_eff = i_alu_req.b;
      cin   = 1'b0;
    end
    sum9      = {1'b0, i_alu_req.a} + {1'b0, b_eff} + {8'h00, cin};
    sum_lo    = {1'b0, i_alu_req.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    sum_low7  = {1'b0, i_alu_req.a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
    carry_in7 = sum_low7[7];
    rot_carry = state_reg.carry_flag;
    case (i_alu_req.op)
      status_flags_pkg::OP_ADD,
      status_flags_pkg::OP_SUB:
      begin
        alu_val = sum9[7:0];
      end
      status_flags_pkg::OP_AND:
      begin
        alu_val = i_alu_req.a & i_alu_req.b;
      end
      status_flags_pkg::OP_OR:
      begin
        alu_val = i_alu_req.a | i_alu_req.b;
      end
      status_flags_pkg::OP_XOR:
      begin
        alu_val = i_alu_req.a ^ i_alu_req.b;
      end
      status_flags_pkg::OP_RLC:
      begin
        alu_val   = {i_alu_req.a[6:0], state_reg.carry_flag};
        rot_carry = i_alu_req.a[7];
      end
      status_flags_pkg::OP_RRC:
      begin
        alu_val   = {state_reg.carry_flag, i_alu_req.a[7:1]};
        rot_carry = i_alu_req.a[0];
      end
      default:
      begin
        alu_val = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // Next state
  // ==========================================================

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_commit;
  logic ar_hit_cf;
  logic ar_hit_sc;

  always_comb
  begin
    state_next = state_reg;
    aw_take    = i_axi_awvalid && !state_reg.aw_held && !state_reg.bvalid;
    w_take     = i_axi_wvalid && !state_reg.w_held && !state_reg.bvalid;
    ar_take    = i_axi_arvalid && !state_reg.rvalid;
    wr_commit  = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
    ar_hit_cf  = i_axi_araddr[`AXI_ADDR_W-1:2] == `CORE_FLAGS_IDX;
    ar_hit_sc  = i_axi_araddr[`AXI_ADDR_W-1:2] == `SYS_CTRL_IDX;

    // Write address and data are caught independently
    if (aw_take)
    begin
      state_next.aw_held = 1'b1;
      state_next.aw_idx  = i_axi_awaddr[`AXI_ADDR_W-1:2];
    end
    if (w_take)
    begin
      state_next.w_held  = 1'b1;
      state_next.w_data  = i_axi_wdata[7:0];
      state_next.w_lane0 = i_axi_wstrb[0];
    end

    // Register write once both halves are held
    if (wr_commit)
    begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = `RESP_OKAY;
      if (state_reg.aw_idx == `CORE_FLAGS_IDX)
      begin
        if (state_reg.w_lane0)
        begin
          // Only arithmetic bits take the written value
          state_next.carry_flag           = state_reg.w_data[`CF_CARRY_BIT];
          state_next.half_carry_flag      = state_reg.w_data[`CF_HALF_BIT];
          state_next.zero_flag            = state_reg.w_data[`CF_ZERO_BIT];
          state_next.signed_overflow_flag = state_reg.w_data[`CF_OVF_BIT];
        end
      end
      else if (state_reg.aw_idx == `SYS_CTRL_IDX)
      begin
        if (state_reg.w_lane0)
        begin
          state_next.idle_clock_keep = state_reg.w_data[`SC_IDLECLK_BIT];
          // Writing zero clears a cause, writing one is ignored
          state_next.wd_enable_reset_cause = state_reg.wd_enable_reset_cause &
                                             state_reg.w_data[`SC_WDEN_BIT];
          state_next.lv_ctrl_write_reset_cause = state_reg.lv_ctrl_write_reset_cause &
                                                 state_reg.w_data[`SC_LVCTRL_BIT];
          state_next.low_voltage_reset_cause = state_reg.low_voltage_reset_cause &
                                               state_reg.w_data[`SC_LVR_BIT];
        end
      end
      else
      begin
        state_next.bresp = `RESP_SLVERR;
      end
    end
    else if (state_reg.bvalid && i_axi_bready)
    begin
      state_next.bvalid = 1'b0;
    end

    // Read channel
    if (ar_take)
    begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = `RESP_OKAY;
      if (ar_hit_cf)
      begin
        state_next.rdata = core_byte(state_reg);
      end
      else if (ar_hit_sc)
      begin
        state_next.rdata = ctrl_byte(state_reg);
      end
      else
      begin
        state_next.rdata = 8'h00;
        state_next.rresp = `RESP_SLVERR;
      end
    end
    else if (state_reg.rvalid && i_axi_rready)
    begin
      state_next.rvalid = 1'b0;
    end

    // ALU update wins over a software write in the same cycle
    state_next.alu_done = i_alu_req.valid;
    if (i_alu_req.valid)
    begin
      state_next.alu_result = alu_val;
      if (is_arith)
      begin
        state_next.carry_flag           = sum9[8];
        state_next.half_carry_flag      = sum_lo[4];
        state_next.signed_overflow_flag = carry_in7 ^ sum9[8];
      end
      if (is_arith || is_logic)
      begin
        state_next.zero_flag = (alu_val == 8'h00);
      end
      if (is_rot)
      begin
        state_next.carry_flag = rot_carry;
      end
    end

    // System flags; a set wins over a clear
    if (i_sys_event.watchdog_clear_instr || i_sys_event.halt)
    begin
      state_next.watchdog_expiry_flag = 1'b0;
    end
    if (i_sys_event.wdt_timeout)
    begin
      state_next.watchdog_expiry_flag = 1'b1;
    end
    if (i_sys_event.watchdog_clear_instr)
    begin
      state_next.power_down_flag = 1'b0;
    end
    if (i_sys_event.halt)
    begin
      state_next.power_down_flag = 1'b1;
    end
    if (i_sys_event.lvr_reset)
    begin
      state_next.low_voltage_reset_cause = 1'b1;
    end
    if (i_sys_event.lv_ctrl_reset)
    begin
      state_next.lv_ctrl_write_reset_cause = 1'b1;
    end
    if (i_sys_event.wd_enable_reset)
    begin
      state_next.wd_enable_reset_cause = 1'b1;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg <= '0;
      state_reg.watchdog_expiry_flag <= `CF_SYS_RST;
      state_reg.power_down_flag      <= `CF_SYS_RST;
      {state_reg.signed_overflow_flag, state_reg.zero_flag,
       state_reg.half_carry_flag, state_reg.carry_flag} <= `CF_ARITH_RST;
      state_reg.idle_clock_keep <= `SC_IDLECLK_RST;
      {state_reg.low_voltage_reset_cause, state_reg.lv_ctrl_write_reset_cause,
       state_reg.wd_enable_reset_cause} <= `SC_CAUSE_RST;
      state_reg.bresp <= `RESP_OKAY;
      state_reg.rresp <= `RESP_OKAY;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================

  assign o_axi_awready          = !state_reg.aw_held && !state_reg.bvalid;
  assign o_axi_wready           = !state_reg.w_held && !state_reg.bvalid;
  assign o_axi_bvalid           = state_reg.bvalid;
  assign o_axi_bresp            = state_reg.bresp;
  assign o_axi_arready          = !state_reg.rvalid;
  assign o_axi_rvalid           = state_reg.rvalid;
  assign o_axi_rdata            = {24'h000000, state_reg.rdata};
  assign o_axi_rresp            = state_reg.rresp;
  assign o_alu_result           = state_reg.alu_result;
  assign o_alu_done             = state_reg.alu_done;
  // Flags leave only through these ports and AXI reads; nothing copies them on call or interrupt
  assign o_core_flags           = core_byte(state_reg);
  assign o_system_control_flags = ctrl_byte(state_reg);
  assign o_idle_clock_keep      = state_reg.idle_clock_keep;

endmodule

// ---- status_flags_defs.svh ----
// Offsets, bit positions, reset values and bus codes of the flag register bank
`ifndef STATUS_FLAGS_DEFS_SVH
`define STATUS_FLAGS_DEFS_SVH

// Register indices; byte address is four times the index
`define CORE_FLAGS_IDX     6'h0a
`define SYS_CTRL_IDX       6'h0c
`define AXI_ADDR_W         8

// Core flags bit positions
`define CF_CARRY_BIT       0
`define CF_HALF_BIT        1
`define CF_ZERO_BIT        2
`define CF_OVF_BIT         3
`define CF_PDOWN_BIT       4
`define CF_WDEXP_BIT       5

// System control bit positions
`define SC_WDEN_BIT        0
`define SC_LVCTRL_BIT      1
`define SC_LVR_BIT         2
`define SC_IDLECLK_BIT     7

// Reset values
`define CF_ARITH_RST       4'h0
`define CF_SYS_RST         1'h0
`define SC_IDLECLK_RST     1'h0
`define SC_CAUSE_RST       3'h0

// Bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ---- status_flags_pkg.sv ----
// Types shared by the flag register bank
package status_flags_pkg;

  // ALU operations that update the arithmetic flags
  typedef enum logic [6:0] {
    OP_ADD = 7'h01,
    OP_SUB = 7'h02,
    OP_AND = 7'h04,
    OP_OR  = 7'h08,
    OP_XOR = 7'h10,
    OP_RLC = 7'h20,
    OP_RRC = 7'h40
  } alu_op_type;

  // One ALU request from the execution core
  typedef struct packed {
    logic       valid;
    alu_op_type op;
    logic [7:0] a;
    logic [7:0] b;
  } alu_req_type;

  // System events from the core, watchdog and reset logic
  typedef struct packed {
    logic watchdog_clear_instr;
    logic halt;
    logic wdt_timeout;
    logic lvr_reset;
    logic lv_ctrl_reset;
    logic wd_enable_reset;
  } sys_event_type;

  // Whole state of the register bank
  typedef struct packed {
    logic       watchdog_expiry_flag;
    logic       power_down_flag;
    logic       signed_overflow_flag;
    logic       zero_flag;
    logic       half_carry_flag;
    logic       carry_flag;
    logic       idle_clock_keep;
    logic       low_voltage_reset_cause;
    logic       lv_ctrl_write_reset_cause;
    logic       wd_enable_reset_cause;
    logic       aw_held;
    logic [5:0] aw_idx;
    logic       w_held;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [7:0] alu_result;
    logic       alu_done;
  } state_type;

endpackage

// ---- status_regs_asserts.sv ----
// Concurrent checks on the flag register bank outputs
`timescale 1ns/1ns

module status_regs_asserts
(
  input wire logic                           i_clk,
  input wire logic                           i_resetn,
  input wire status_flags_pkg::alu_req_type   i_alu_req,
  input wire status_flags_pkg::sys_event_type i_sys_event,
  input wire logic [7:0]                     o_alu_result,
  input wire logic                           o_alu_done,
  input wire logic [7:0]                     o_core_flags,
  input wire logic [7:0]                     o_system_control_flags
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // ==========================================
  // System flags
  unimpl_zero_a: assert property (o_core_flags[7:6] == 2'h0)
    else $error("core flag top bits not zero");
  wd_set_a: assert property (i_sys_event.wdt_timeout |=> o_core_flags[5])
    else $error("expiry flag not set");
  wd_clr_a: assert property ((i_sys_event.watchdog_clear_instr || i_sys_event.halt) &&
    !i_sys_event.wdt_timeout |=> !o_core_flags[5]) else $error("expiry flag not cleared");
  pd_set_a: assert property (i_sys_event.halt |=> o_core_flags[4])
    else $error("power-down flag not set");
  pd_clr_a: assert property (i_sys_event.watchdog_clear_instr && !i_sys_event.halt |=> !o_core_flags[4])
    else $error("power-down flag not cleared");
  sys_hold_a: assert property (!(i_sys_event.watchdog_clear_instr || i_sys_event.halt ||
    i_sys_event.wdt_timeout) |=> $stable(o_core_flags[5:4])) else $error("system flags moved");
  lv_set_a: assert property (i_sys_event.lvr_reset |=> o_system_control_flags[2])
    else $error("low-voltage cause not set");
  cause_rise_a: assert property ($rose(o_system_control_flags[1]) |->
    $past(i_sys_event.lv_ctrl_reset)) else $error("cause flag set by software");

  // ==========================================
  // Arithmetic flags
  add_carry_a: assert property (o_alu_done && $past(i_alu_req.op) == 7'h01 |->
    o_core_flags[0] == (o_alu_result < $past(i_alu_req.a))) else $error("add carry wrong");
  rlc_carry_a: assert property (o_alu_done && $past(i_alu_req.op) == 7'h20 |->
    o_core_flags[0] == $past(i_alu_req.a[7]) && o_alu_result[0] == $past(o_core_flags[0]))
    else $error("rotate carry wrong");
  zero_flag_a: assert property (o_alu_done && $past(i_alu_req.op[6:5]) == 2'h0 |->
    o_core_flags[2] == (o_alu_result == 8'h00)) else $error("zero flag wrong");
  add_ovf_a: assert property (o_alu_done && $past(i_alu_req.op) == 7'h01 |->
    o_core_flags[3] == ($past(i_alu_req.a[7]) == $past(i_alu_req.b[7]) &&
    o_alu_result[7] != $past(i_alu_req.a[7]))) else $error("overflow flag wrong");

  halt_c: cover property (i_sys_event.halt);
  ovf_c: cover property (o_alu_done && o_core_flags[3]);
  race_c: cover property (i_sys_event.wdt_timeout && i_sys_event.watchdog_clear_instr);
endmodule

bind status_and_reset_flag_regs status_regs_asserts u_chk
(
  .i_clk(i_clk), .i_resetn(i_resetn), .i_alu_req(i_alu_req), .i_sys_event(i_sys_event),
  .o_alu_result(o_alu_result), .o_alu_done(o_alu_done), .o_core_flags(o_core_flags),
  .o_system_control_flags(o_system_control_flags)
);

// ---- tb_top.sv ----
// Self-checking bench for the flag register bank
`timescale 1ns/1ns
`include "status_flags_defs.svh"

module tb_top;
  localparam logic [7:0] CF_A = {`CORE_FLAGS_IDX, 2'b00};
  localparam logic [7:0] SC_A = {`SYS_CTRL_IDX, 2'b00};
  logic             i_clk;
  logic             i_resetn;
  logic             awv, wv, bry, arv, rry;
  logic [7:0]       awa, ara;
  logic [31:0]      wd;
  logic [3:0]       ws;
  wire logic        awr, wrd, bv, arr, rv, done, keep;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rdt;
  wire logic [7:0]  res, cf, sc;
  wire status_flags_pkg::alu_req_type   req;
  wire status_flags_pkg::sys_event_type sev;
  logic [5:0]       evs [7] = '{6'h10, 6'h08, 6'h28, 6'h20, 6'h30, 6'h18, 6'h10};
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int m_cf = 0;
  int m_sc = 0;

  status_and_reset_flag_regs DUT
  (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_axi_awvalid(awv), .o_axi_awready(awr),
    .i_axi_awaddr(awa), .i_axi_wvalid(wv), .o_axi_wready(wrd), .i_axi_wdata(wd),
    .i_axi_wstrb(ws), .o_axi_bvalid(bv), .i_axi_bready(bry), .o_axi_bresp(br),
    .i_axi_arvalid(arv), .o_axi_arready(arr), .i_axi_araddr(ara), .o_axi_rvalid(rv),
    .i_axi_rready(rry), .o_axi_rdata(rdt), .o_axi_rresp(rr), .i_alu_req(req),
    .i_sys_event(sev), .o_alu_result(res), .o_alu_done(done), .o_core_flags(cf),
    .o_system_control_flags(sc), .o_idle_clock_keep(keep)
  );
  core_model PEER (.i_clk(i_clk), .o_alu_req(req), .o_sys_event(sev));

  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count++;
      conclude();
    end
  end

  // ==========================================
  // Compare and bus tasks
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rsp(input logic [1:0] got, input logic [7:0] a);
    chk_val({30'h0, got}, (a == CF_A || a == SC_A) ? `RESP_OKAY : `RESP_SLVERR);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!bv)
    begin
      @(posedge i_clk);
      if (awv && awr)
        awv <= 1'b0;
      if (wv && wrd)
        wv <= 1'b0;
    end
    bry <= 1'b0;
    chk_rsp(br, a);
    if (a == CF_A && ws[0])
      m_cf = (m_cf & 'h30) | (d & 'h0f);
    if (a == SC_A && ws[0])
      m_sc = (d & 'h80) | (m_sc & d & 'h07);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    while (!rv)
    begin
      @(posedge i_clk);
      if (arv && arr)
        arv <= 1'b0;
    end
    rry <= 1'b0;
    chk_val(rdt, a == CF_A ? m_cf : a == SC_A ? m_sc : 0);
    chk_rsp(rr, a);
  endtask

  // ==========================================
  // Core-side tasks with the reference model
  task automatic ev(input logic [5:0] e);
    PEER.pulse(e);
    if (e[3])
      m_cf = m_cf | 'h20;
    else if (e[5] || e[4])
      m_cf = m_cf & 'hdf;
    if (e[4])
      m_cf = m_cf | 'h10;
    else if (e[5])
      m_cf = m_cf & 'hef;
    m_sc = m_sc | e[2:0];
    #1;
    chk_val({cf, sc}, {m_cf[7:0], m_sc[7:0]});
  endtask

  task automatic op(input int k, input int a, input int b);
    int bb, ci, s, r, c, v, h;
    bb = (k == 1) ? (~b & 'hff) : b;
    ci = (k == 1);
    s = a + bb + ci;
    c = m_cf & 1;
    if (k < 2)
    begin
      r = s & 'hff;
      v = (((a & 127) + (bb & 127) + ci) >> 7) ^ (s >> 8);
      h = ((a & 15) + (bb & 15) + ci) >> 4;
      m_cf = (m_cf & 'h30) | (v << 3) | ((r == 0) << 2) | (h << 1) | (s >> 8);
    end
    else if (k < 5)
    begin
      r = (k == 2) ? (a & b) : (k == 3) ? (a | b) : (a ^ b);
      m_cf = (m_cf & 'hfb) | ((r == 0) << 2);
    end
    else
    begin
      r = (k == 5) ? (((a << 1) | c) & 'hff) : ((a >> 1) | (c << 7));
      m_cf = (m_cf & 'hfe) | ((k == 5) ? (a >> 7) : (a & 1));
    end
    PEER.alu(status_flags_pkg::alu_op_type'(7'h01 << k), 8'(a), 8'(b));
    #1;
    chk_val({done, res, cf}, {1'b1, 8'(r), 8'(m_cf)});
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    i_resetn = 1'b0;
    {awv, wv, bry, arv, rry} = '0;
    {awa, ara, wd} = '0;
    ws = 4'hf;
    void'($urandom(6389));
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(CF_A);
    rd(SC_A);
    end_test("reset");
    wr(CF_A, 8'hff);
    rd(CF_A);
    foreach (evs[i])
    begin
      ev(evs[i]);
      wr(CF_A, 8'($urandom));
      rd(CF_A);
    end
    end_test("status");
    // Power-up in mid-run must clear the system flags left set above
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    m_cf = 0;
    m_sc = 0;
    rd(CF_A);
    end_test("power-up");
    op(0, 'h0f, 'h01);
    op(0, 'h7f, 'h01);
    op(0, 'hff, 'h01);
    op(1, 'h00, 'h01);
    op(1, 'h10, 'h01);
    op(1, 'h80, 'h01);
    op(5, 'h80, 'h00);
    op(6, 'h01, 'h00);
    repeat (80) op($urandom_range(6, 0), $urandom_range(255, 0), $urandom_range(255, 0));
    end_test("alu");
    wr(SC_A, 8'h80);
    chk_val(keep, 1);
    for (int i = 0; i < 3; i++)
    begin
      ev(6'h01 << i);
      wr(SC_A, 8'hff);
      rd(SC_A);
      wr(SC_A, 8'hff ^ (8'h01 << i));
      rd(SC_A);
    end
    end_test("control");
    rd(8'h2c);
    wr(8'h04, 8'h5a);
    rd(CF_A);
    // A write without the low byte lane must leave the flags alone
    wr(CF_A, 8'h05);
    ws <= 4'he;
    wr(CF_A, 8'h0a);
    ws <= 4'hf;
    rd(CF_A);
    end_test("unmapped");
    conclude();
  end
endmodule
